// *** hdl/tcm_top.sv ***
// Timer control and interrupt mask register block, classic Wishbone slave
// Assumes the counter datapath supplies raw PWM levels and event pulses
// on this clock; capture pins arrive asynchronously.
//
// How it works
// RULE1: Half-B PWM output is inverted when control bit 14 is set.
// RULE2: Half-B output trigger passes only while control bit 13 is set.
// RULE3: Control bits 11:10 pick half-B capture edge: rise, fall, reserved, both.
// RULE4: Half-B may stall on debug halt only when control bit 9 is set.
// RULE5: Control bit 8 starts half-B counting or capture per configuration.
// RULE6: Half-A PWM output is inverted when control bit 6 is set.
// RULE7: Half-A output trigger passes only while control bit 5 is set.
// RULE8: Clock counting runs only while control bit 4 is set.
// RULE9: Control bits 3:2 pick half-A capture edge: rise, fall, reserved, both.
// RULE10: Half-A may stall on debug halt only when control bit 1 is set.
// RULE11: Control bit 0 starts half-A counting or capture per configuration.
// RULE12: Reserved bits are read-only; software leaves them unchanged.
// RULE13: Writing a mask bit one enables its interrupt, zero disables it.
// RULE14: Mask bits 10, 9, 8 enable half-B capture event, match, time-out.
// RULE15: Mask bits 2, 1, 0 enable half-A capture event, match, time-out.
// RULE16: Mask bit 3 enables the clock event interrupt, reset off.
// RULE17: All writable control bits reset to zero.
// RULE18: Raw status bits set on their event whatever the mask.
// RULE19: Masked status is raw and mask; writing one to clear drops it.
// RULE20: Configuration picks one wide timer, clock counter or two halves.
// RULE21: PWM on a half needs alternate set, capture style clear, mode two.
// RULE22: The interrupt output is high while any masked status bit is set.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_top
    import tcm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ccp_a_i,
    input wire logic ccp_b_i,
    input wire logic dbg_halt_i,
    input wire logic pwm_a_raw_i,
    input wire logic pwm_b_raw_i,
    input wire logic a_timeout_i,
    input wire logic a_match_i,
    input wire logic b_timeout_i,
    input wire logic b_match_i,
    input wire logic clk_event_i,
    output logic [2:0] cfg_o,
    output logic [3:0] a_mode_o,
    output logic [3:0] b_mode_o,
    output logic a_count_en_o,
    output logic a_capture_en_o,
    output logic b_count_en_o,
    output logic b_capture_en_o,
    output logic clk_count_en_o,
    output logic a_stall_o,
    output logic b_stall_o,
    output logic pwm_a_o,
    output logic pwm_b_o,
    output logic trig_a_o,
    output logic trig_b_o,
    output logic a_cap_event_o,
    output logic b_cap_event_o,
    output logic irq_o
);

    tcm_state_t st_r;
    tcm_state_t st_nxt;
    logic [1:0] pin_w;
    logic [1:0] cap_en_w;
    logic [1:0] edge_sel_w [2];
    logic [1:0] cap_pulse_w;
    logic [10:0] evt_w;
    logic [10:0] clr_w;
    logic req_new;
    logic req_done;

    // Address decode, used for every register
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction

    // Byte-lane write merge limited to the writable bits
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel, input logic [31:0] wm);
        logic [31:0] lane;
        lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wm;
        wmerge = (old & ~lane) | (d & lane);
    endfunction

    // Half selected for capture when alternate is clear and mode is capture
    function automatic logic is_capture(input logic [3:0] m);
        is_capture = ~m[`TCM_MODE_ALT] & (m[`TCM_MODE_FLD_HI:0] == `TCM_MODE_CAPTURE);
    endfunction

    // Capture edge detectors, one per half
    assign pin_w = {ccp_b_i, ccp_a_i};
    assign cap_en_w = {st_r.b_cap, st_r.a_cap};
    assign edge_sel_w[0] = st_r.ctl[`TCM_CTL_A_EDGE_HI:`TCM_CTL_A_EDGE_LO]; // RULE9
    assign edge_sel_w[1] = st_r.ctl[`TCM_CTL_B_EDGE_HI:`TCM_CTL_B_EDGE_LO]; // RULE3

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_edge
            tcm_edge_unit u_edge (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(pin_w[g]),
                .en_i(cap_en_w[g]),
                .sel_i(edge_sel_w[g]),
                .pulse_o(cap_pulse_w[g])
            );
        end
    endgenerate

    // Event vector in status bit order
    always_comb begin
        evt_w = '0;
        evt_w[`TCM_EV_A_TO] = a_timeout_i;
        evt_w[`TCM_EV_A_MATCH] = a_match_i;
        evt_w[`TCM_EV_A_CAP] = cap_pulse_w[0];
        evt_w[`TCM_EV_CLK] = clk_event_i;
        evt_w[`TCM_EV_B_TO] = b_timeout_i;
        evt_w[`TCM_EV_B_MATCH] = b_match_i;
        evt_w[`TCM_EV_B_CAP] = cap_pulse_w[1];
    end

    // Bus phases: answer one cycle after the request, commit while ack is high
    assign req_new = wb_cyc_i & wb_stb_i & ~st_r.ack;
    assign req_done = wb_cyc_i & wb_stb_i & st_r.ack;
    assign clr_w = (req_done && wb_we_i && hit(wb_adr_i, `TCM_OFF_CLR)) ?
                   11'(wmerge(32'h00000000, wb_dat_i, wb_sel_i, `TCM_EVT_WMASK)) :
                   11'h000;

    // Next state of the whole block
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = req_new;
        // Read data captured with ack; reserved bits read as zero
        if (req_new && !wb_we_i) begin
            st_nxt.dat = 32'h00000000;
            if (hit(wb_adr_i, `TCM_OFF_CFG)) begin
                st_nxt.dat = {29'h0, st_r.cfg};
            end else if (hit(wb_adr_i, `TCM_OFF_AMODE)) begin
                st_nxt.dat = {28'h0, st_r.amode};
            end else if (hit(wb_adr_i, `TCM_OFF_BMODE)) begin
                st_nxt.dat = {28'h0, st_r.bmode};
            end else if (hit(wb_adr_i, `TCM_OFF_CTL)) begin
                st_nxt.dat = {17'h0, st_r.ctl}; // RULE12
            end else if (hit(wb_adr_i, `TCM_OFF_MASK)) begin
                st_nxt.dat = {21'h0, st_r.mask};
            end else if (hit(wb_adr_i, `TCM_OFF_RAW)) begin
                st_nxt.dat = {21'h0, st_r.raw};
            end else if (hit(wb_adr_i, `TCM_OFF_MIS)) begin
                st_nxt.dat = {21'h0, st_r.raw & st_r.mask}; // RULE19
            end
        end else if (req_new) begin
            st_nxt.dat = 32'h00000000;
        end
        // Writes land on the edge at which the master samples ack
        if (req_done && wb_we_i) begin
            if (hit(wb_adr_i, `TCM_OFF_CFG)) begin
                st_nxt.cfg = 3'(wmerge({29'h0, st_r.cfg}, wb_dat_i, wb_sel_i,
                                       `TCM_CFG_WMASK)); // RULE20
            end
            if (hit(wb_adr_i, `TCM_OFF_AMODE)) begin
                st_nxt.amode = 4'(wmerge({28'h0, st_r.amode}, wb_dat_i, wb_sel_i,
                                         `TCM_MODE_WMASK)); // RULE21
            end
            if (hit(wb_adr_i, `TCM_OFF_BMODE)) begin
                st_nxt.bmode = 4'(wmerge({28'h0, st_r.bmode}, wb_dat_i, wb_sel_i,
                                         `TCM_MODE_WMASK));
            end
            if (hit(wb_adr_i, `TCM_OFF_CTL)) begin
                // Reserved bits 31:15, 12 and 7 are never written
                st_nxt.ctl = 15'(wmerge({17'h0, st_r.ctl}, wb_dat_i, wb_sel_i,
                                        `TCM_CTL_WMASK)); // RULE12
            end
            if (hit(wb_adr_i, `TCM_OFF_MASK)) begin
                // One enables, zero disables each implemented source
                st_nxt.mask = 11'(wmerge({21'h0, st_r.mask}, wb_dat_i, wb_sel_i,
                                         `TCM_EVT_WMASK)); // RULE13 RULE14 RULE15 RULE16
            end
        end
        // Raw status: set regardless of mask, a new event beats a clear
        st_nxt.raw = (st_r.raw & ~clr_w) | evt_w; // RULE18 RULE19
        // Interrupt follows the masked status
        st_nxt.irq = |(st_r.raw & st_r.mask); // RULE22
        // Run enables per configuration
        st_nxt.a_cnt = 1'b0;
        st_nxt.a_cap = 1'b0;
        st_nxt.b_cnt = 1'b0;
        st_nxt.b_cap = 1'b0;
        st_nxt.clk_cnt = 1'b0;
        if (st_r.cfg[`TCM_CFG_SPLIT_BIT]) begin
            st_nxt.a_cap = st_r.ctl[`TCM_CTL_A_RUN] & is_capture(st_r.amode); // RULE11
            st_nxt.a_cnt = st_r.ctl[`TCM_CTL_A_RUN] & ~is_capture(st_r.amode);
            st_nxt.b_cap = st_r.ctl[`TCM_CTL_B_RUN] & is_capture(st_r.bmode); // RULE5
            st_nxt.b_cnt = st_r.ctl[`TCM_CTL_B_RUN] & ~is_capture(st_r.bmode);
        end else if (st_r.cfg == `TCM_CFG_CLOCK) begin
            st_nxt.clk_cnt = st_r.ctl[`TCM_CTL_A_RUN] & st_r.ctl[`TCM_CTL_CLK_CNT]; // RULE8
        end else if (st_r.cfg == `TCM_CFG_WHOLE) begin
            st_nxt.a_cnt = st_r.ctl[`TCM_CTL_A_RUN]; // RULE20
        end
        // Debug stall gating
        st_nxt.stall_a = dbg_halt_i & st_r.ctl[`TCM_CTL_A_STALL]; // RULE10
        st_nxt.stall_b = dbg_halt_i & st_r.ctl[`TCM_CTL_B_STALL]; // RULE4
        // Output polarity
        st_nxt.pwm_a = pwm_a_raw_i ^ st_r.ctl[`TCM_CTL_A_INV]; // RULE6
        st_nxt.pwm_b = pwm_b_raw_i ^ st_r.ctl[`TCM_CTL_B_INV]; // RULE1
        // Output triggers on time-out
        st_nxt.trig_a = a_timeout_i & st_r.ctl[`TCM_CTL_A_TRIG]; // RULE7
        st_nxt.trig_b = b_timeout_i & st_r.ctl[`TCM_CTL_B_TRIG]; // RULE2
    end

    // State register; everything clears to zero on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0; // RULE17
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register, capture events from the edge units
    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;
    assign cfg_o = st_r.cfg;
    assign a_mode_o = st_r.amode;
    assign b_mode_o = st_r.bmode;
    assign a_count_en_o = st_r.a_cnt;
    assign a_capture_en_o = st_r.a_cap;
    assign b_count_en_o = st_r.b_cnt;
    assign b_capture_en_o = st_r.b_cap;
    assign clk_count_en_o = st_r.clk_cnt;
    assign a_stall_o = st_r.stall_a;
    assign b_stall_o = st_r.stall_b;
    assign pwm_a_o = st_r.pwm_a;
    assign pwm_b_o = st_r.pwm_b;
    assign trig_a_o = st_r.trig_a;
    assign trig_b_o = st_r.trig_b;
    assign a_cap_event_o = cap_pulse_w[0];
    assign b_cap_event_o = cap_pulse_w[1];
    assign irq_o = st_r.irq;

    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_pwm_b_invert: assert property ( // RULE1
        ##1 pwm_b_o == ($past(pwm_b_raw_i) ^ $past(st_r.ctl[`TCM_CTL_B_INV])))
        else $error("Half B PWM polarity wrong");
    chk_pwm_a_invert: assert property ( // RULE6
        ##1 pwm_a_o == ($past(pwm_a_raw_i) ^ $past(st_r.ctl[`TCM_CTL_A_INV])))
        else $error("Half A PWM polarity wrong");
    chk_trig_b_gate: assert property ( // RULE2
        !st_r.ctl[`TCM_CTL_B_TRIG] |=> !trig_b_o)
        else $error("Half B trigger while disabled");
    chk_trig_a_pass: assert property ( // RULE7
        (a_timeout_i && st_r.ctl[`TCM_CTL_A_TRIG]) |=> trig_a_o)
        else $error("Half A trigger lost");
    chk_stall_a_gate: assert property ( // RULE10
        ##1 a_stall_o == ($past(dbg_halt_i) && $past(st_r.ctl[`TCM_CTL_A_STALL])))
        else $error("Half A stall wrong");
    chk_stall_b_gate: assert property ( // RULE4
        !st_r.ctl[`TCM_CTL_B_STALL] |=> !b_stall_o)
        else $error("Half B stalled while disabled");
    chk_run_b_off: assert property ( // RULE5
        !st_r.ctl[`TCM_CTL_B_RUN] |=> !b_count_en_o && !b_capture_en_o)
        else $error("Half B runs while disabled");
    chk_run_a_off: assert property ( // RULE11
        !st_r.ctl[`TCM_CTL_A_RUN] |=> !a_count_en_o && !a_capture_en_o && !clk_count_en_o)
        else $error("Half A runs while disabled");
    chk_clock_gate: assert property ( // RULE8
        !st_r.ctl[`TCM_CTL_CLK_CNT] |=> !clk_count_en_o)
        else $error("Clock counts while disabled");
    chk_raw_sets: assert property ( // RULE18
        (b_match_i && !st_r.mask[`TCM_EV_B_MATCH]) |=> st_r.raw[`TCM_EV_B_MATCH])
        else $error("Raw status missed an event");
    chk_clear_drops: assert property ( // RULE19
        (clr_w[`TCM_EV_A_TO] && !a_timeout_i) |=> !st_r.raw[`TCM_EV_A_TO])
        else $error("Clear did not drop status");
    chk_irq_follow: assert property ( // RULE22
        (|(st_r.raw & st_r.mask)) |=> irq_o)
        else $error("Interrupt missing");
    chk_irq_quiet: assert property ( // RULE22
        (st_r.mask == 11'h000) |=> !irq_o)
        else $error("Interrupt with all sources masked");
    chk_mask_write: assert property ( // RULE13
        (req_done && wb_we_i && hit(wb_adr_i, `TCM_OFF_MASK) && wb_sel_i == 4'hf)
        |=> st_r.mask == ($past(wb_dat_i[10:0]) & 11'h70f))
        else $error("Mask write not stored");
    chk_reset_zero: assert property ( // RULE17
        $past(rst_i) |-> st_r.ctl == 15'h0000 && st_r.mask == 11'h000)
        else $error("Control not cleared by reset");
    chk_bus_answer: assert property (
        req_new |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Bus answer timing wrong");

endmodule

// *** hdl/tcm_consts.svh ***
// Named constants for the timer control and interrupt mask block
// Assumes byte addresses on an 8-bit slice of the bus address
`ifndef TCM_CONSTS_SVH
`define TCM_CONSTS_SVH

// Register byte offsets
`define TCM_OFF_CFG 8'h00
`define TCM_OFF_AMODE 8'h04
`define TCM_OFF_BMODE 8'h08
`define TCM_OFF_CTL 8'h0c
`define TCM_OFF_MASK 8'h18
`define TCM_OFF_RAW 8'h1c
`define TCM_OFF_MIS 8'h20
`define TCM_OFF_CLR 8'h24

// Writable bit masks and reset values
`define TCM_CFG_WMASK 32'h00000007
`define TCM_MODE_WMASK 32'h0000000f
`define TCM_CTL_WMASK 32'h00006f7f
`define TCM_EVT_WMASK 32'h0000070f
`define TCM_CFG_RST 3'h0
`define TCM_MODE_RST 4'h0
`define TCM_CTL_RST 15'h0000
`define TCM_EVT_RST 11'h000

// Control bit positions
`define TCM_CTL_A_RUN 0
`define TCM_CTL_A_STALL 1
`define TCM_CTL_A_EDGE_LO 2
`define TCM_CTL_A_EDGE_HI 3
`define TCM_CTL_CLK_CNT 4
`define TCM_CTL_A_TRIG 5
`define TCM_CTL_A_INV 6
`define TCM_CTL_B_RUN 8
`define TCM_CTL_B_STALL 9
`define TCM_CTL_B_EDGE_LO 10
`define TCM_CTL_B_EDGE_HI 11
`define TCM_CTL_B_TRIG 13
`define TCM_CTL_B_INV 14

// Event bit positions in mask, raw and masked status
`define TCM_EV_A_TO 0
`define TCM_EV_A_MATCH 1
`define TCM_EV_A_CAP 2
`define TCM_EV_CLK 3
`define TCM_EV_B_TO 8
`define TCM_EV_B_MATCH 9
`define TCM_EV_B_CAP 10

// Mode field layout and encodings
`define TCM_MODE_ALT 3
`define TCM_MODE_FLD_HI 1
`define TCM_MODE_CAPTURE 2'h3
`define TCM_CFG_WHOLE 3'h0
`define TCM_CFG_CLOCK 3'h1
`define TCM_CFG_SPLIT_BIT 2

// Capture edge encodings
`define TCM_EDGE_RISE 2'h0
`define TCM_EDGE_FALL 2'h1
`define TCM_EDGE_RSVD 2'h2
`define TCM_EDGE_BOTH 2'h3

`endif

// *** hdl/tcm_pkg.sv ***
// Types shared by the timer control and interrupt mask block
// Assumes the constants header is compiled alongside
package tcm_pkg;

    // Whole state of the register block
    typedef struct packed {
        logic [2:0] cfg;
        logic [3:0] amode;
        logic [3:0] bmode;
        logic [14:0] ctl;
        logic [10:0] mask;
        logic [10:0] raw;
        logic ack;
        logic [31:0] dat;
        logic pwm_a;
        logic pwm_b;
        logic trig_a;
        logic trig_b;
        logic stall_a;
        logic stall_b;
        logic a_cnt;
        logic a_cap;
        logic b_cnt;
        logic b_cap;
        logic clk_cnt;
        logic irq;
    } tcm_state_t;

    // Whole state of one capture edge detector
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic pulse;
    } tcm_edge_t;

endpackage

// *** hdl/tcm_edge_unit.sv ***
// Capture pin synchroniser and selectable edge detector
// Assumes an asynchronous pin and a same-clock enable and edge select
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tcm_edge_unit
    import tcm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic en_i,
    input wire logic [1:0] sel_i,
    output logic pulse_o
);

    tcm_edge_t st_r;
    tcm_edge_t st_nxt;
    logic rise;
    logic fall;

    // Edges are seen only past the second synchroniser stage
    assign rise = st_r.s2 & ~st_r.prev;
    assign fall = ~st_r.s2 & st_r.prev;

    // Next state: sync chain and edge selection
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        st_nxt.pulse = 1'b0;
        if (en_i) begin
            unique case (sel_i)
                `TCM_EDGE_RISE: st_nxt.pulse = rise;
                `TCM_EDGE_FALL: st_nxt.pulse = fall;
                `TCM_EDGE_BOTH: st_nxt.pulse = rise | fall;
                `TCM_EDGE_RSVD: st_nxt.pulse = 1'b0; // Reserved code detects nothing
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse_o = st_r.pulse;

    chk_edge_reserved_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        (sel_i == `TCM_EDGE_RSVD) |=> !pulse_o) else $error("Edge seen on reserved select");
    chk_edge_fall_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (en_i && sel_i == `TCM_EDGE_FALL && rise) |=> !pulse_o)
        else $error("Rising edge taken in falling mode");

endmodule

// *** testbench/tb_tcm_top.sv ***
// Self-checking bench for the timer control and interrupt mask block
// Assumes the block answers each Wishbone request with a one-cycle ack
`timescale 1ns/1ps
`include "tcm_consts.svh"

module tb_tcm_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic ccp_a = 1'b0, ccp_b = 1'b0, halt = 1'b0, pa = 1'b0, pb = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, a_count_en_o, a_capture_en_o, b_count_en_o, b_capture_en_o;
    logic clk_count_en_o, a_stall_o, b_stall_o, pwm_a_o, pwm_b_o, trig_a_o, trig_b_o;
    logic a_cap_event_o, b_cap_event_o, irq_o;
    logic [2:0] cfg_o;
    logic [3:0] a_mode_o, b_mode_o;
    logic [32:0] exp_q[$];
    logic [32:0] e;
    int fail_count = 0;
    int checks_done = 0;
    integer seed = 32'heef2;
    int pos[5] = '{0, 1, 3, 8, 9};
    // Run-enable table: cfg, A mode, B mode, control, {a_cnt,a_cap,b_cnt,b_cap,clk}
    logic [31:0] runs[8] = '{{3'h0, 4'h0, 4'h0, 16'h0001, 5'h10},
        {3'h0, 4'h0, 4'h0, 16'h0100, 5'h00}, {3'h1, 4'h0, 4'h0, 16'h0011, 5'h01},
        {3'h1, 4'h0, 4'h0, 16'h0001, 5'h00}, {3'h4, 4'h2, 4'h3, 16'h0101, 5'h12},
        {3'h7, 4'h3, 4'ha, 16'h0101, 5'h0c}, {3'h4, 4'h2, 4'h3, 16'h0000, 5'h00},
        {3'h2, 4'h2, 4'h2, 16'h0111, 5'h00}};

    // Clock at 40 MHz
    always #12.5 clk_i = ~clk_i;

    tcm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ccp_a_i(ccp_a), .ccp_b_i(ccp_b), .dbg_halt_i(halt),
        .pwm_a_raw_i(pa), .pwm_b_raw_i(pb), .a_timeout_i(ev[0]), .a_match_i(ev[1]),
        .b_timeout_i(ev[3]), .b_match_i(ev[4]), .clk_event_i(ev[2]), .cfg_o(cfg_o),
        .a_mode_o(a_mode_o), .b_mode_o(b_mode_o), .a_count_en_o(a_count_en_o),
        .a_capture_en_o(a_capture_en_o), .b_count_en_o(b_count_en_o),
        .b_capture_en_o(b_capture_en_o), .clk_count_en_o(clk_count_en_o),
        .a_stall_o(a_stall_o), .b_stall_o(b_stall_o), .pwm_a_o(pwm_a_o),
        .pwm_b_o(pwm_b_o), .trig_a_o(trig_a_o), .trig_b_o(trig_b_o),
        .a_cap_event_o(a_cap_event_o), .b_cap_event_o(b_cap_event_o), .irq_o(irq_o));

    task automatic note_err(input string m);
        fail_count++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            note_err($sformatf("%s got %h expected %h", m, got, exp));
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One classic cycle; the expected read word is noted before the request goes out
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] x);
        int n;
        exp_q.push_back(x);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            note_err("bus timeout");
            finish_test();
        end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 32'h0, {1'b1, x});
    endtask

    task automatic pulse(input int i);
        @(posedge clk_i);
        ev[i] <= 1'b1;
        @(posedge clk_i);
        ev <= 5'h00;
        repeat (2) @(posedge clk_i);
    endtask

    // Takes the oldest note at each ack and compares read data
    always @(posedge clk_i) begin
        if (!rst_i && wb_ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                note_err("ack with no request");
            end else begin
                e = exp_q.pop_front();
                if (e[32]) begin
                    cmp(wb_dat_o, e[31:0], "read data");
                end
            end
        end
    end

    // Cuts a hang short
    initial begin
        repeat (60000) @(posedge clk_i);
        note_err("run timeout");
        finish_test();
    end

    // Main sequence
    initial begin
        int rc, fc;
        logic [31:0] d, c;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`TCM_OFF_CTL, 32'h0);
        rd(`TCM_OFF_MASK, 32'h0);
        rd(`TCM_OFF_RAW, 32'h0);
        rd(`TCM_OFF_CLR, 32'h0);
        rd(8'h40, 32'h0);
        cmp({27'h0, a_count_en_o, b_count_en_o, clk_count_en_o, irq_o, pwm_a_o}, 0, "rst");
        $display("test reset done");
        wr(`TCM_OFF_CTL, 32'hffffffff);
        rd(`TCM_OFF_CTL, 32'h00006f7f);
        wr(`TCM_OFF_MASK, 32'hffffffff);
        rd(`TCM_OFF_MASK, 32'h0000070f);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(`TCM_OFF_CTL, d);
            rd(`TCM_OFF_CTL, d & `TCM_CTL_WMASK);
            wr(`TCM_OFF_MASK, d);
            rd(`TCM_OFF_MASK, d & `TCM_EVT_WMASK);
        end
        wr(`TCM_OFF_MASK, 32'h0);
        $display("test registers done");
        // Inversion, stall and trigger for all four enable pairs
        halt <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            c = (k[0] ? 32'h00000062 : 32'h0) | (k[1] ? 32'h00006200 : 32'h0);
            pa <= d[0];
            pb <= d[1];
            wr(`TCM_OFF_CTL, c);
            repeat (3) @(posedge clk_i);
            cmp({31'h0, pwm_a_o}, d[0] ^ k[0], "pwm a");
            cmp({31'h0, pwm_b_o}, d[1] ^ k[1], "pwm b");
            cmp({31'h0, a_stall_o}, k[0], "stall a");
            cmp({31'h0, b_stall_o}, k[1], "stall b");
            @(posedge clk_i);
            ev <= 5'b01001;
            @(posedge clk_i);
            ev <= 5'h00;
            @(posedge clk_i);
            cmp({30'h0, trig_a_o, trig_b_o}, {k[0], k[1]}, "trigger");
            @(posedge clk_i);
            cmp({30'h0, trig_a_o, trig_b_o}, 0, "trigger end");
        end
        halt <= 1'b0;
        rd(`TCM_OFF_RAW, 32'h00000101);
        wr(`TCM_OFF_CLR, 32'h0000070f);
        $display("test outputs done");
        for (int r = 0; r < 8; r++) begin
            wr(`TCM_OFF_CFG, {29'h0, runs[r][31:29]});
            wr(`TCM_OFF_AMODE, {28'h0, runs[r][28:25]});
            wr(`TCM_OFF_BMODE, {28'h0, runs[r][24:21]});
            wr(`TCM_OFF_CTL, {16'h0, runs[r][20:5]});
            repeat (3) @(posedge clk_i);
            cmp({27'h0, a_count_en_o, a_capture_en_o, b_count_en_o, b_capture_en_o,
                 clk_count_en_o}, {27'h0, runs[r][4:0]}, "run enables");
            cmp({21'h0, cfg_o, a_mode_o, b_mode_o}, {21'h0, runs[r][31:21]}, "config out");
        end
        $display("test run enables done");
        // Capture edges for every select code on both halves
        wr(`TCM_OFF_CFG, 32'h4);
        wr(`TCM_OFF_AMODE, 32'h3);
        wr(`TCM_OFF_BMODE, 32'h3);
        for (int h = 0; h < 2; h++) begin
            for (int s = 0; s < 4; s++) begin
                wr(`TCM_OFF_CTL, (32'h1 | (s << 2)) << (8 * h));
                repeat (3) @(posedge clk_i);
                rc = 0;
                fc = 0;
                if (h == 1) ccp_b <= 1'b1; else ccp_a <= 1'b1;
                repeat (8) begin
                    @(posedge clk_i);
                    rc += ((h == 1 ? b_cap_event_o : a_cap_event_o) === 1'b1);
                end
                if (h == 1) ccp_b <= 1'b0; else ccp_a <= 1'b0;
                repeat (8) begin
                    @(posedge clk_i);
                    fc += ((h == 1 ? b_cap_event_o : a_cap_event_o) === 1'b1);
                end
                cmp(rc, (s == 0 || s == 3), "rise count");
                cmp(fc, (s == 1 || s == 3), "fall count");
            end
        end
        rd(`TCM_OFF_RAW, 32'h00000404);
        wr(`TCM_OFF_CLR, 32'h0000070f);
        $display("test capture done");
        // Each of the five non-capture event sources with its mask off, then on, then cleared
        for (int i = 0; i < 5; i++) begin
            c = 32'h1 << pos[i];
            pulse(i);
            rd(`TCM_OFF_RAW, c);
            rd(`TCM_OFF_MIS, 32'h0);
            cmp({31'h0, irq_o}, 0, "irq masked");
            wr(`TCM_OFF_MASK, c);
            rd(`TCM_OFF_MIS, c);
            repeat (2) @(posedge clk_i);
            cmp({31'h0, irq_o}, 1, "irq raised");
            wr(`TCM_OFF_CLR, c);
            rd(`TCM_OFF_RAW, 32'h0);
            repeat (2) @(posedge clk_i);
            cmp({31'h0, irq_o}, 0, "irq cleared");
            wr(`TCM_OFF_MASK, 32'h0);
        end
        $display("test interrupts done");
        repeat (3) @(posedge clk_i);
        finish_test();
    end
endmodule
